// File: common/loc_pkg.sv
// Shared constants and types for the logic output conditioning block
package loc_pkg;
    // Source selection
    localparam int SEL_W = 6;
    localparam logic [5:0] SEL_NONE = 6'h00;
    localparam logic [5:0] SEL_NO_FAULT = 6'h01;
    localparam logic [5:0] SEL_BRAKE_CTRL = 6'h02;
    localparam logic [5:0] SEL_OUTPUT_CONTACTOR = 6'h03;
    localparam logic [5:0] SEL_DC_PRECHARGE = 6'h04;
    localparam logic [5:0] SEL_LINE_CONTACTOR = 6'h05;

    // Timing
    localparam int DELAY_W = 16;
    localparam int HOLD_W = 14;
    localparam logic [15:0] DELAY_MAX_MS = 16'hEA60;
    localparam logic [13:0] HOLD_MAX_MS = 14'h270F;
    localparam logic [15:0] DELAY_RESET = 16'h0000;
    localparam logic [13:0] HOLD_RESET = 14'h0000;
    localparam logic ACTIVE_LOW_RESET = 1'b0;
    localparam int MS_NS = 1000000;
    localparam int CLK_PERIOD_NS = 4;
    localparam int TICK_CYCLES = MS_NS / CLK_PERIOD_NS;

    // Register byte offsets (address bits [4:2])
    localparam logic [4:0] OFS_CFG_THREE = 5'h00;
    localparam logic [4:0] OFS_DELAY_THREE = 5'h04;
    localparam logic [4:0] OFS_HOLD_THREE = 5'h08;
    localparam logic [4:0] OFS_CFG_FOUR = 5'h0C;
    localparam logic [4:0] OFS_DELAY_FOUR = 5'h10;
    localparam logic [4:0] OFS_HOLD_FOUR = 5'h14;
    localparam logic [4:0] OFS_STATUS = 5'h18;

    // Field positions
    localparam int CFG_SEL_LSB = 0;
    localparam int CFG_ACTIVE_LOW_BIT = 8;
    localparam int ST_CARD_BIT = 0;
    localparam int ST_OUT_THREE_BIT = 1;
    localparam int ST_OUT_FOUR_BIT = 2;
    localparam int ST_SRC_THREE_BIT = 3;
    localparam int ST_SRC_FOUR_BIT = 4;

    typedef struct packed {
        logic [SEL_W-1:0] sel;
        logic active_low;
        logic [DELAY_W-1:0] delay_ms;
        logic [HOLD_W-1:0] hold_ms;
    } loc_cfg_t;

    typedef enum logic [1:0] {
        LOC_OFF = 2'b00,
        LOC_DELAY = 2'b01,
        LOC_ON = 2'b10,
        LOC_HOLD = 2'b11
    } loc_state_t;
endpackage : loc_pkg

// File: src/loc_channel.sv
// One conditioned logic output: assertion delay, hold time and polarity
`timescale 1ns/1ns
`default_nettype none
module loc_channel (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Time base and source
    input wire logic tick_ms,
    input wire logic source,
    input wire loc_pkg::loc_cfg_t cfg,
    // Result
    output logic asserted,
    output logic pin
);
    import loc_pkg::*;

    loc_state_t state;
    loc_state_t next_state;
    logic [DELAY_W-1:0] count;
    logic restart;

    always_comb begin
        next_state = state;
        unique case (state)
            LOC_OFF: begin
                if (source) begin
                    next_state = (cfg.delay_ms == DELAY_RESET) ? LOC_ON : LOC_DELAY;
                end
            end
            LOC_DELAY: begin
                if (!source) begin
                    next_state = LOC_OFF;
                end else if (count >= cfg.delay_ms) begin
                    next_state = LOC_ON;
                end
            end
            LOC_ON: begin
                if (!source) begin
                    next_state = (cfg.hold_ms == HOLD_RESET) ? LOC_OFF : LOC_HOLD;
                end
            end
            LOC_HOLD: begin
                if (source) begin
                    next_state = LOC_ON;
                end else if (count >= DELAY_W'(cfg.hold_ms)) begin
                    next_state = LOC_OFF;
                end
            end
        endcase
    end

    assign restart = (next_state != state);

    // Timer restarts on every state change, so a source that bounces back starts afresh
    always_ff @(posedge clk) begin
        if (rst || restart) begin
            count <= '0;
        end else if (tick_ms && count != '1) begin
            count <= count + DELAY_W'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state <= LOC_OFF;
        end else begin
            state <= next_state;
        end
    end

    // Pin carries the polarity applied to the next logical state
    always_ff @(posedge clk) begin
        if (rst) begin
            asserted <= 1'b0;
            pin <= ACTIVE_LOW_RESET;
        end else begin
            asserted <= next_state[1];
            pin <= next_state[1] ^ cfg.active_low;
        end
    end
endmodule : loc_channel
`default_nettype wire

// File: src/loc_top.sv
// Logic output conditioning for the third and fourth extension logic outputs
// What this block does
// - Configuration of both outputs is reachable only while the extension card is detected.
// - Each output selects its source from the common set, with no source after reset.
// - A rising source changes the output only after a delay of 0 to 60000 ms, default 0.
// - Delay is forced to zero and other values refused for the five fixed sources.
// - Positive polarity (default) gives 1 while the source is true, negative gives 0.
// - Polarity is locked positive for no-fault, brake, precharge and line contactor sources.
// - A falling source releases the output only after a hold of 0 to 9999 ms, default 0.
// - Hold is forced to zero for no-fault, brake, precharge and line contactor sources.
`timescale 1ns/1ns
`default_nettype none
module loc_top #(
    parameter int SRC_COUNT = 64,
    parameter int TICK_DIV = loc_pkg::TICK_CYCLES
) (
    // Clock and reset
    input wire logic MCLK,
    input wire logic RST,
    // Wishbone slave
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [4:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    // Drive status sources and card detection
    input wire logic [SRC_COUNT-1:0] STATUS_SOURCES,
    input wire logic CARD_PRESENT,
    // Conditioned outputs
    output logic LOGIC_OUTPUT_THREE,
    output logic LOGIC_OUTPUT_FOUR
);
    import loc_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Shared millisecond time base
    logic [31:0] div_count;
    logic tick_ms;

    always_ff @(posedge MCLK) begin
        if (RST) begin
            div_count <= '0;
            tick_ms <= 1'b0;
        end else if (div_count == 32'(TICK_DIV - 1)) begin
            div_count <= '0;
            tick_ms <= 1'b1;
        end else begin
            div_count <= div_count + 32'h0000_0001;
            tick_ms <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register access
    loc_cfg_t cfg [2];
    logic [1:0] src_now;
    logic [1:0] asserted;
    logic [1:0] pins;
    logic wr_stb;
    logic rd_stb;
    logic [31:0] wdata;

    assign wr_stb = WB_CYC_I && WB_STB_I && WB_WE_I && !WB_ACK_O;
    assign rd_stb = WB_CYC_I && WB_STB_I && !WB_ACK_O;

    // Byte enables merge into the current contents of the addressed word
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] sel);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                res[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        return res;
    endfunction : merge

    // Sources whose delay may never be set
    function automatic logic fixed_delay(input logic [SEL_W-1:0] s);
        return s inside {SEL_NO_FAULT, SEL_BRAKE_CTRL, SEL_OUTPUT_CONTACTOR,
                         SEL_DC_PRECHARGE, SEL_LINE_CONTACTOR};
    endfunction : fixed_delay

    // Output contactor keeps adjustable hold and polarity
    function automatic logic fixed_hold_pol(input logic [SEL_W-1:0] s);
        return s inside {SEL_NO_FAULT, SEL_BRAKE_CTRL, SEL_DC_PRECHARGE, SEL_LINE_CONTACTOR};
    endfunction : fixed_hold_pol

    function automatic logic [31:0] cfg_word(input loc_cfg_t c);
        logic [31:0] w;
        w = '0;
        w[CFG_SEL_LSB +: SEL_W] = c.sel;
        w[CFG_ACTIVE_LOW_BIT] = c.active_low;
        return w;
    endfunction : cfg_word

    for (genvar i = 0; i < 2; i++) begin : g_cfg
        localparam logic [4:0] OFS_CFG = (i == 0) ? OFS_CFG_THREE : OFS_CFG_FOUR;
        localparam logic [4:0] OFS_DELAY = (i == 0) ? OFS_DELAY_THREE : OFS_DELAY_FOUR;
        localparam logic [4:0] OFS_HOLD = (i == 0) ? OFS_HOLD_THREE : OFS_HOLD_FOUR;
        logic [31:0] cw;
        logic [SEL_W-1:0] new_sel;
        logic [31:0] dw;
        logic [31:0] hw;

        assign cw = merge(cfg_word(cfg[i]), WB_DAT_I, WB_SEL_I);
        assign new_sel = cw[CFG_SEL_LSB +: SEL_W];
        assign dw = merge({16'h0000, cfg[i].delay_ms}, WB_DAT_I, WB_SEL_I);
        assign hw = merge({18'h00000, cfg[i].hold_ms}, WB_DAT_I, WB_SEL_I);

        always_ff @(posedge MCLK) begin
            if (RST) begin
                cfg[i].sel <= SEL_NONE;
                cfg[i].active_low <= ACTIVE_LOW_RESET;
                cfg[i].delay_ms <= DELAY_RESET;
                cfg[i].hold_ms <= HOLD_RESET;
            end else if (wr_stb && CARD_PRESENT) begin
                if (WB_ADR_I == OFS_CFG) begin
                    cfg[i].sel <= new_sel;
                    cfg[i].active_low <= cw[CFG_ACTIVE_LOW_BIT] && !fixed_hold_pol(new_sel);
                    if (fixed_delay(new_sel)) begin
                        cfg[i].delay_ms <= DELAY_RESET;
                    end
                    if (fixed_hold_pol(new_sel)) begin
                        cfg[i].hold_ms <= HOLD_RESET;
                    end
                end else if (WB_ADR_I == OFS_DELAY) begin
                    // Out-of-range or locked values are refused, the old value stays
                    if (!fixed_delay(cfg[i].sel) && dw[31:16] == 16'h0000
                        && dw[15:0] <= DELAY_MAX_MS) begin
                        cfg[i].delay_ms <= dw[15:0];
                    end
                end else if (WB_ADR_I == OFS_HOLD) begin
                    if (!fixed_hold_pol(cfg[i].sel) && hw[31:14] == 18'h00000
                        && hw[13:0] <= HOLD_MAX_MS) begin
                        cfg[i].hold_ms <= hw[13:0];
                    end
                end
            end
        end

        // Code zero selects nothing and never asserts
        assign src_now[i] = (cfg[i].sel != SEL_NONE) && (32'(cfg[i].sel) < SRC_COUNT)
                            && STATUS_SOURCES[cfg[i].sel];

        loc_channel u_channel (
            .clk(MCLK),
            .rst(RST),
            .tick_ms(tick_ms),
            .source(src_now[i]),
            .cfg(cfg[i]),
            .asserted(asserted[i]),
            .pin(pins[i])
        );
    end

    always_comb begin
        wdata = 32'h0000_0000;
        if (WB_ADR_I == OFS_STATUS) begin
            wdata[ST_CARD_BIT] = CARD_PRESENT;
            wdata[ST_OUT_THREE_BIT] = asserted[0];
            wdata[ST_OUT_FOUR_BIT] = asserted[1];
            wdata[ST_SRC_THREE_BIT] = src_now[0];
            wdata[ST_SRC_FOUR_BIT] = src_now[1];
        end else if (CARD_PRESENT) begin
            unique case (WB_ADR_I)
                OFS_CFG_THREE: wdata = cfg_word(cfg[0]);
                OFS_DELAY_THREE: wdata = {16'h0000, cfg[0].delay_ms};
                OFS_HOLD_THREE: wdata = {18'h00000, cfg[0].hold_ms};
                OFS_CFG_FOUR: wdata = cfg_word(cfg[1]);
                OFS_DELAY_FOUR: wdata = {16'h0000, cfg[1].delay_ms};
                OFS_HOLD_FOUR: wdata = {18'h00000, cfg[1].hold_ms};
                default: wdata = 32'h0000_0000;
            endcase
        end
    end

    // Every access is acknowledged one cycle after it starts, unmapped ones read zero
    always_ff @(posedge MCLK) begin
        if (RST) begin
            WB_ACK_O <= 1'b0;
            WB_DAT_O <= 32'h0000_0000;
        end else begin
            WB_ACK_O <= rd_stb;
            WB_DAT_O <= rd_stb ? wdata : 32'h0000_0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Output pins
    always_ff @(posedge MCLK) begin
        if (RST) begin
            LOGIC_OUTPUT_THREE <= ACTIVE_LOW_RESET;
            LOGIC_OUTPUT_FOUR <= ACTIVE_LOW_RESET;
        end else begin
            LOGIC_OUTPUT_THREE <= pins[0];
            LOGIC_OUTPUT_FOUR <= pins[1];
        end
    end
endmodule : loc_top
`default_nettype wire

// File: bench/loc_top_sva.sv
// Port checker for the logic output conditioning block
`timescale 1ns/1ns
`default_nettype none
module loc_top_sva
import loc_pkg::*;
(
    // Clock and reset
    input wire logic MCLK,
    input wire logic RST,
    // Register bus
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [4:0] WB_ADR_I,
    input wire logic [31:0] WB_DAT_O,
    input wire logic WB_ACK_O,
    // Card and outputs
    input wire logic CARD_PRESENT,
    input wire logic LOGIC_OUTPUT_THREE,
    input wire logic LOGIC_OUTPUT_FOUR
);
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (RST);
    sequence s_req;
        WB_CYC_I && WB_STB_I && !WB_ACK_O;
    endsequence
    sequence s_rd_ack;
        WB_ACK_O && !WB_WE_I;
    endsequence
    chk_ack_follows: assert property (s_req |=> WB_ACK_O)
        else $error("ack missing one cycle after request");
    chk_ack_pulse: assert property (WB_ACK_O |=> !WB_ACK_O)
        else $error("ack longer than one cycle");
    chk_ack_cause: assert property ($rose(WB_ACK_O) |-> $past(WB_CYC_I && WB_STB_I))
        else $error("ack without request");
    chk_dat_quiet: assert property (!WB_ACK_O |-> WB_DAT_O == 32'h0)
        else $error("read data not zero outside ack");
    chk_card_blocks: assert property (
        s_rd_ack ##0 (!$past(CARD_PRESENT) && $past(WB_ADR_I) < OFS_STATUS) |-> WB_DAT_O == 0)
        else $error("config readable without card");
    chk_card_status: assert property (
        s_rd_ack ##0 ($past(WB_ADR_I) == OFS_STATUS) |-> WB_DAT_O[0] == $past(CARD_PRESENT))
        else $error("status card bit wrong");
    chk_unmapped_zero: assert property (
        s_rd_ack ##0 ($past(WB_ADR_I) > OFS_STATUS) |-> WB_DAT_O == 32'h0)
        else $error("unmapped read not zero");
    chk_reset_idle: assert property ($past(RST) |-> !LOGIC_OUTPUT_THREE && !LOGIC_OUTPUT_FOUR)
        else $error("outputs not idle after reset");
endmodule : loc_top_sva
bind loc_top loc_top_sva i_loc_top_sva (.MCLK, .RST, .WB_CYC_I, .WB_STB_I, .WB_WE_I,
    .WB_ADR_I, .WB_DAT_O, .WB_ACK_O, .CARD_PRESENT, .LOGIC_OUTPUT_THREE, .LOGIC_OUTPUT_FOUR);
`default_nettype wire

// File: bench/loc_relay.sv
// Relay model driven by one conditioned output
`timescale 1ns/1ns
`default_nettype none
module loc_relay #(parameter int PICKUP = 3) (
    // Clock
    input wire logic clk,
    // Coil and contact
    input wire logic coil,
    output logic contact
);
    logic state = 1'b0;
    int settle = 0;
    assign contact = state;
    // A coil pulse shorter than the pickup time moves the contact only when it starts the cycle after the contact moved
    always_ff @(posedge clk) begin
        if (coil === state) begin
            settle <= 0;
        end else if (settle + 1 >= PICKUP) begin
            state <= coil;
        end else begin
            settle <= settle + 1;
        end
    end
endmodule : loc_relay
`default_nettype wire

// File: bench/test_logic_output_conditioning.sv
// Self-checking bench for the logic output conditioning block
`timescale 1ns/1ns
`default_nettype none
module test_logic_output_conditioning;
    import loc_pkg::*;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic req = 1'b0;
    logic we = 1'b0;
    logic [4:0] adr = 5'h00;
    logic [31:0] wdat = 32'h0;
    logic [3:0] sel = 4'hF;
    logic [63:0] src = 64'h0;
    logic card = 1'b1;
    logic [31:0] rdat;
    logic ack, out3, out4, relay;
    logic [31:0] expq[$];
    int n_mismatch = 0;
    int n_compared = 0;
    int s3, s4;
    loc_top #(.TICK_DIV(10)) i_loc_top (.MCLK(mclk), .RST(rst), .WB_CYC_I(req),
        .WB_STB_I(req), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat),
        .WB_DAT_O(rdat), .WB_ACK_O(ack), .STATUS_SOURCES(src), .CARD_PRESENT(card),
        .LOGIC_OUTPUT_THREE(out3), .LOGIC_OUTPUT_FOUR(out4));
    loc_relay i_loc_relay (.clk(mclk), .coil(out3), .contact(relay));
    ////////////////////////////////////////
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // Waits for ack however long it takes; only the watchdog ends a hung access
    task automatic wb(input logic [4:0] a, input logic w, input logic [31:0] d);
        @(posedge mclk);
        req <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge mclk);
        end while (ack !== 1'b1);
        req <= 1'b0;
    endtask : wb
    task automatic rd(input logic [4:0] a, input logic [31:0] exp);
        expq.push_back(exp);
        wb(a, 1'b0, 32'h0);
    endtask : rd
    task automatic wt(input int n);
        repeat (n) @(posedge mclk);
    endtask : wt
    task automatic complete_run;
        // A read still waiting for its answer is a failure too
        if (expq.size() != 0) begin
            n_mismatch++;
        end
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : complete_run
    ////////////////////////////////////////
    initial forever #2 mclk = ~mclk;
    // Read data is judged by the oldest note, in issue order
    always @(posedge mclk) begin
        if (ack === 1'b1 && we === 1'b0 && expq.size() > 0) begin
            check("read data", rdat, expq.pop_front());
        end
    end
    initial begin
        wt(5000);
        n_mismatch++;
        complete_run();
    end
    initial begin
        void'($urandom(32'hF79B14AF));
        s3 = 6 + $urandom % 58;
        s4 = 6 + (s3 - 5) % 58;
        wt(10);
        rst <= 1'b0;
        src <= {$urandom, $urandom} & ~((64'h1 << s3) | (64'h1 << s4) | 64'h1);
        rd(OFS_CFG_THREE, 32'h0);
        rd(OFS_DELAY_FOUR, 32'h0);
        rd(OFS_HOLD_FOUR, 32'h0);
        rd(OFS_STATUS, 32'h1);
        rd(5'h1C, 32'h0);
        $display("reset values done");
        card <= 1'b0;
        wb(OFS_CFG_FOUR, 1'b1, 32'h9);
        rd(OFS_CFG_FOUR, 32'h0);
        card <= 1'b1;
        rd(OFS_CFG_FOUR, 32'h0);
        $display("card absent done");
        wb(OFS_DELAY_THREE, 1'b1, 32'hEA61);
        rd(OFS_DELAY_THREE, 32'h0);
        wb(OFS_DELAY_THREE, 1'b1, 32'hEA60);
        rd(OFS_DELAY_THREE, 32'hEA60);
        sel <= 4'h1;
        wb(OFS_DELAY_THREE, 1'b1, 32'hFFFF_FF05);
        sel <= 4'hF;
        rd(OFS_DELAY_THREE, 32'hEA05);
        wb(OFS_HOLD_FOUR, 1'b1, 32'h2710);
        rd(OFS_HOLD_FOUR, 32'h0);
        wb(OFS_HOLD_FOUR, 1'b1, 32'h270F);
        rd(OFS_HOLD_FOUR, 32'h270F);
        $display("ranges done");
        for (int c = 1; c <= 5; c++) begin
            wb(OFS_CFG_THREE, 1'b1, 32'h6);
            wb(OFS_DELAY_THREE, 1'b1, 32'h5);
            wb(OFS_HOLD_THREE, 1'b1, 32'h7);
            wb(OFS_CFG_THREE, 1'b1, 32'h100 | 32'(c));
            rd(OFS_CFG_THREE, (c == 3) ? 32'h103 : 32'(c));
            rd(OFS_DELAY_THREE, 32'h0);
            wb(OFS_DELAY_THREE, 1'b1, 32'h9);
            rd(OFS_DELAY_THREE, 32'h0);
            rd(OFS_HOLD_THREE, (c == 3) ? 32'h7 : 32'h0);
        end
        $display("locked sources done");
        wb(OFS_CFG_THREE, 1'b1, 32'(s3));
        wb(OFS_DELAY_THREE, 1'b1, 32'h3);
        wb(OFS_HOLD_THREE, 1'b1, 32'h2);
        wb(OFS_CFG_FOUR, 1'b1, 32'h100 | 32'(s4));
        wb(OFS_HOLD_FOUR, 1'b1, 32'h0);
        wt(5);
        check("out four idle", 32'(out4), 32'h1);
        src <= src | (64'h1 << s3);
        wt(15);
        check("out three early", 32'(out3), 32'h0);
        src <= src ^ ((64'h1 << s3) | (64'h1 << s4));
        wt(5);
        check("out four on", 32'(out4), 32'h0);
        src <= src | (64'h1 << s3);
        wt(15);
        check("out three restart", 32'(out3), 32'h0);
        wt(25);
        check("out three on", 32'(out3), 32'h1);
        rd(OFS_STATUS, 32'h1F);
        src <= src & ~(64'h1 << s3);
        wt(5);
        check("out three hold", 32'(out3), 32'h1);
        wt(30);
        check("out three off", 32'(out3), 32'h0);
        check("relay open", 32'(relay), 32'h0);
        $display("timing done");
        complete_run();
    end
endmodule : test_logic_output_conditioning
`default_nettype wire
